// ### logic/oasl_pkg.sv
// Shared constants and carrier types for the octal serial line block
package oasl_pkg;

  // ==========================================================
  // Clock and bit timing
  // ==========================================================
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD = 9600;
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int HALF_CYC = (BIT_CYC + 1) / 2;
  localparam logic [10:0] BIT_CNT = BIT_CYC[10:0];
  localparam logic [10:0] HALF_CNT = HALF_CYC[10:0];
  localparam logic [10:0] CNT_ONE = 11'h001;

  // ==========================================================
  // Register map, selected by the low address bits
  // ==========================================================
  localparam int NUM_LINES = 8;
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_MODE = 3'h2;
  localparam logic [2:0] REG_CMD = 3'h3;
  localparam logic [2:0] REG_INT_SUM = 3'h4;
  localparam logic [2:0] REG_MDM_SUM = 3'h5;
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // Frame sizes
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  localparam logic [3:0] LAST_FRAME_BIT = 4'h9;

  // ==========================================================
  // Carrier types
  // ==========================================================
  typedef struct packed {
    logic [2:0] line;
    logic [2:0] sel;
  } oasl_addr_type;

  typedef struct packed {
    logic [1:0] spare;
    logic rcv_int_enable;
    logic err_reset;
    logic send_break;
    logic rcv_enable;
    logic xmt_int_enable;
    logic xmt_enable;
  } oasl_cmd_type;

  typedef struct packed {
    logic [7:0] data;
    logic ready;
    logic frame_err;
    logic overrun;
  } oasl_rx_type;

endpackage : oasl_pkg

// ### logic/oasl_rx.sv
// One line receiver: start detect, deserializer and two-entry FIFO
`timescale 1ns/1ns
module oasl_rx (
  input wire logic clock, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic rxd, // Serial input
  input wire logic enable, // Receive enable
  input wire logic pop, // Buffer read strobe
  input wire logic err_clr, // Error reset pulse
  output oasl_pkg::oasl_rx_type rx_out // Buffer head and flags
);
  import oasl_pkg::*;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} oasl_rx_state_type;

  oasl_rx_state_type state_ff, nxt_state;
  logic [10:0] cnt_ff, nxt_cnt, hi_ff, nxt_hi;
  logic [2:0] bits_ff, nxt_bits;
  logic [7:0] shift_ff, nxt_shift, fifo0_ff, nxt_fifo0, fifo1_ff, nxt_fifo1;
  logic [1:0] count_ff, nxt_count;
  logic prev_ff, ferr_ff, nxt_ferr, ovr_ff, nxt_ovr;
  logic push, bad_stop;

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + CNT_ONE;
    nxt_bits = bits_ff;
    nxt_shift = shift_ff;
    nxt_fifo0 = fifo0_ff;
    nxt_fifo1 = fifo1_ff;
    nxt_count = count_ff;
    nxt_ferr = ferr_ff;
    nxt_ovr = ovr_ff;
    push = 1'b0;
    bad_stop = 1'b0;
    // High time saturates at half a bit
    nxt_hi = !rxd ? 11'h000 : (hi_ff == HALF_CNT) ? hi_ff : hi_ff + CNT_ONE;
    unique case (state_ff)
      RX_IDLE: begin
        // Only an edge after a half bit of idle counts
        if (prev_ff && !rxd && hi_ff == HALF_CNT) begin
          nxt_state = RX_START;
        end
        nxt_cnt = CNT_ONE;
      end
      RX_START: begin
        if (cnt_ff == HALF_CNT) begin
          // Glitch shorter than half a bit is not a start
          nxt_state = rxd ? RX_IDLE : RX_DATA;
          nxt_cnt = CNT_ONE;
          nxt_bits = 3'h0;
        end
      end
      RX_DATA: begin
        if (cnt_ff == BIT_CNT) begin
          nxt_shift = {rxd, shift_ff[7:1]};
          nxt_cnt = CNT_ONE;
          nxt_bits = bits_ff + 3'h1;
          if (bits_ff == LAST_DATA_BIT) begin
            nxt_state = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (cnt_ff == BIT_CNT) begin
          push = 1'b1;
          bad_stop = !rxd;
          nxt_state = RX_IDLE;
        end
      end
    endcase
    // FIFO: pop first so a full buffer read frees room for a push
    if (pop && count_ff != 2'h0) begin
      nxt_fifo0 = fifo1_ff;
      nxt_count = count_ff - 2'h1;
    end
    if (err_clr) begin
      nxt_ferr = 1'b0;
      nxt_ovr = 1'b0;
    end
    if (push) begin
      if (nxt_count == 2'h2) begin
        nxt_ovr = 1'b1;
      end else begin
        if (nxt_count == 2'h0) begin
          nxt_fifo0 = shift_ff;
        end else begin
          nxt_fifo1 = shift_ff;
        end
        nxt_count = nxt_count + 2'h1;
        nxt_ferr = bad_stop;
      end
    end
    // Disabled receiver drops everything in flight
    if (!enable) begin
      nxt_state = RX_IDLE;
      nxt_count = 2'h0;
      nxt_ferr = 1'b0;
      nxt_ovr = 1'b0;
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= RX_IDLE;
      cnt_ff <= 11'h000;
      hi_ff <= 11'h000;
      bits_ff <= 3'h0;
      shift_ff <= 8'h00;
      fifo0_ff <= 8'h00;
      fifo1_ff <= 8'h00;
      count_ff <= 2'h0;
      prev_ff <= 1'b0;
      ferr_ff <= 1'b0;
      ovr_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      hi_ff <= nxt_hi;
      bits_ff <= nxt_bits;
      shift_ff <= nxt_shift;
      fifo0_ff <= nxt_fifo0;
      fifo1_ff <= nxt_fifo1;
      count_ff <= nxt_count;
      prev_ff <= rxd;
      ferr_ff <= nxt_ferr;
      ovr_ff <= nxt_ovr;
    end
  end

  // Whole carrier from one assignment, fields in declared order
  assign rx_out = {fifo0_ff, (count_ff != 2'h0), ferr_ff, ovr_ff};

endmodule : oasl_rx

// ### logic/oasl_tx.sv
// One line transmitter: holding register and serializer
`timescale 1ns/1ns
module oasl_tx (
  input wire logic clock, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic enable, // Transmit enable
  input wire logic brk, // Send break
  input wire logic load, // Holding register write
  input wire logic [7:0] load_data, // Character written
  output logic txd, // Serial output, from a flop
  output logic ready, // Holding register empty
  output logic empty // Nothing left to send
);
  import oasl_pkg::*;

  logic [7:0] hold_ff, nxt_hold;
  logic [9:0] shift_ff, nxt_shift;
  logic [3:0] bits_ff, nxt_bits;
  logic [10:0] cnt_ff, nxt_cnt;
  logic full_ff, nxt_full, busy_ff, nxt_busy, txd_ff, nxt_txd;

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    nxt_hold = hold_ff;
    nxt_shift = shift_ff;
    nxt_bits = bits_ff;
    nxt_cnt = cnt_ff + CNT_ONE;
    nxt_full = full_ff;
    nxt_busy = busy_ff;
    if (!busy_ff) begin
      // Disable only stalls the move; the held character survives
      if (enable && full_ff) begin
        nxt_shift = {1'b1, hold_ff, 1'b0};
        nxt_busy = 1'b1;
        nxt_full = 1'b0;
        nxt_bits = 4'h0;
      end
      nxt_cnt = CNT_ONE;
    end else if (cnt_ff == BIT_CNT) begin
      nxt_cnt = CNT_ONE;
      nxt_shift = {1'b1, shift_ff[9:1]};
      nxt_bits = bits_ff + 4'h1;
      if (bits_ff == LAST_FRAME_BIT) begin
        nxt_busy = 1'b0;
      end
    end
    // A write while full overwrites the held character
    if (load) begin
      nxt_hold = load_data;
      nxt_full = 1'b1;
    end
    // Break wins, idle rests high
    nxt_txd = brk ? 1'b0 : nxt_busy ? nxt_shift[0] : 1'b1;
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hold_ff <= 8'h00;
      shift_ff <= 10'h3FF;
      bits_ff <= 4'h0;
      cnt_ff <= 11'h000;
      full_ff <= 1'b0;
      busy_ff <= 1'b0;
      txd_ff <= 1'b0;
    end else begin
      hold_ff <= nxt_hold;
      shift_ff <= nxt_shift;
      bits_ff <= nxt_bits;
      cnt_ff <= nxt_cnt;
      full_ff <= nxt_full;
      busy_ff <= nxt_busy;
      txd_ff <= nxt_txd;
    end
  end

  assign txd = txd_ff;
  assign ready = enable && !full_ff;
  assign empty = enable && !full_ff && !busy_ff;

endmodule : oasl_tx

// ### logic/oasl_top.sv
// Eight-line asynchronous receiver/transmitter with interrupt scanner
`timescale 1ns/1ns

module oasl_top (
  input wire logic clock, // System clock, 10 MHz
  input wire logic arst_n, // Async reset, active low
  input oasl_pkg::oasl_addr_type addr, // Line and register select
  input wire logic [7:0] wdata, // Write data
  input wire logic wr_stb, // Write strobe
  input wire logic rd_stb, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after strobe
  input wire logic chip_sel_n, // Chip select, active low
  input wire logic rdy_in, // Ready pin level, unused
  output logic rdy_out, // Ready pin drive value
  output logic rdy_oe, // Ready pin pulled low when high
  input wire logic irq_in, // Interrupt pin level, unused
  output logic irq_out, // Interrupt pin drive value
  output logic irq_oe, // Interrupt pin pulled low when high
  output logic int_line_num_msb, // Interrupting line bit 2
  output logic int_line_num_mid, // Interrupting line bit 1
  output logic int_line_num_lsb, // Interrupting line bit 0
  output logic service_direction, // High transmit, low receive
  input wire logic [7:0] rxd, // Serial inputs
  output logic [7:0] txd, // Serial outputs
  input wire logic [7:0] dsr_n, // Data set ready, active low
  input wire logic [7:0] carrier_det, // Carrier detect pins
  input wire logic factory_test_reset // Tied low on the board
);
  import oasl_pkg::*;

  typedef enum logic {SC_SCAN, SC_HALT} oasl_scan_type;

  // ==========================================================
  // Declarations
  // ==========================================================
  oasl_cmd_type cmd_ff [NUM_LINES];
  oasl_cmd_type nxt_cmd [NUM_LINES];
  logic [7:0] mode1_ff [NUM_LINES];
  logic [7:0] nxt_mode1 [NUM_LINES];
  logic [7:0] mode2_ff [NUM_LINES];
  logic [7:0] nxt_mode2 [NUM_LINES];
  logic [7:0] mptr_ff;
  logic [7:0] nxt_mptr;
  oasl_rx_type rx_st [NUM_LINES];
  logic [7:0] rx_ready;
  logic [7:0] tx_ready;
  logic [7:0] tx_empty;
  logic [7:0] pop;
  logic [7:0] load;
  logic [7:0] err_clr;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] status [NUM_LINES];
  logic [7:0] mchg_ff;
  logic [7:0] nxt_mchg;
  logic [7:0] dsr_prev_ff;
  logic [7:0] dcd_prev_ff;
  logic primed_ff;
  logic cs_prev_ff;
  logic rdy_oe_ff;
  logic nxt_rdy_oe;
  oasl_scan_type scan_ff;
  oasl_scan_type nxt_scan;
  logic [2:0] scan_line_ff;
  logic [2:0] nxt_scan_line;
  logic [2:0] int_line_ff;
  logic [2:0] nxt_int_line;
  logic dir_ff;
  logic nxt_dir;
  logic irq_oe_ff;
  logic nxt_irq_oe;
  logic data_acc;
  logic rx_cause;
  logic tx_cause;

  // ==========================================================
  // Per-line receivers and transmitters
  // ==========================================================
  // Data address shares one slot: read pops, write loads
  assign data_acc = (addr.sel == REG_DATA);

  for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
    assign pop[i] = rd_stb && data_acc && addr.line == 3'(i);
    assign load[i] = wr_stb && data_acc && addr.line == 3'(i);
    assign err_clr[i] = wr_stb && addr.sel == REG_CMD && addr.line == 3'(i) && wdata[4];

    oasl_rx u_rx (
      .clock(clock),
      .arst_n(arst_n),
      .rxd(rxd[i]),
      .enable(cmd_ff[i].rcv_enable),
      .pop(pop[i]),
      .err_clr(err_clr[i]),
      .rx_out(rx_st[i])
    );

    oasl_tx u_tx (
      .clock(clock),
      .arst_n(arst_n),
      .enable(cmd_ff[i].xmt_enable),
      .brk(cmd_ff[i].send_break),
      .load(load[i]),
      .load_data(wdata),
      .txd(txd[i]),
      .ready(tx_ready[i]),
      .empty(tx_empty[i])
    );

    assign rx_ready[i] = rx_st[i].ready;
    // Status word: modem levels, errors, empty and ready flags
    assign status[i] = {~dsr_n[i], carrier_det[i], rx_st[i].frame_err,
                        rx_st[i].overrun, 1'b0, tx_empty[i], rx_ready[i], tx_ready[i]};
  end

  // ==========================================================
  // Command and mode registers
  // ==========================================================
  // Writes land here; any mode access or a command read moves the pointer
  always_comb begin
    nxt_mptr = mptr_ff;
    for (int i = 0; i < NUM_LINES; i++) begin
      nxt_cmd[i] = cmd_ff[i];
      nxt_mode1[i] = mode1_ff[i];
      nxt_mode2[i] = mode2_ff[i];
    end
    if ((wr_stb || rd_stb) && addr.sel == REG_MODE) begin
      // Any access flips between the two mode registers
      if (wr_stb && !mptr_ff[addr.line]) begin
        nxt_mode1[addr.line] = wdata;
      end
      if (wr_stb && mptr_ff[addr.line]) begin
        nxt_mode2[addr.line] = wdata;
      end
      nxt_mptr[addr.line] = !mptr_ff[addr.line];
    end
    if (rd_stb && addr.sel == REG_CMD) begin
      nxt_mptr[addr.line] = 1'b0;
    end
    if (wr_stb && addr.sel == REG_CMD) begin
      // Error reset acts once and is never stored
      nxt_cmd[addr.line] = oasl_cmd_type'(wdata & 8'hEF);
    end
  end

  // Reset leaves both directions of every line switched off
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mptr_ff <= 8'h00;
      for (int i = 0; i < NUM_LINES; i++) begin
        cmd_ff[i] <= oasl_cmd_type'(CMD_RST);
        mode1_ff[i] <= MODE_RST;
        mode2_ff[i] <= MODE_RST;
      end
    end else begin
      mptr_ff <= nxt_mptr;
      for (int i = 0; i < NUM_LINES; i++) begin
        cmd_ff[i] <= nxt_cmd[i];
        mode1_ff[i] <= nxt_mode1[i];
        mode2_ff[i] <= nxt_mode2[i];
      end
    end
  end

  // ==========================================================
  // Modem change summary
  // ==========================================================
  // Inputs are sampled each clock, so 100 ns pulses may show up too
  always_comb begin
    nxt_mchg = mchg_ff;
    if (rd_stb && addr.sel == REG_MDM_SUM) begin
      nxt_mchg = 8'h00;
    end
    // Set after clear so a change in the read cycle survives
    if (primed_ff) begin
      nxt_mchg = nxt_mchg | (dsr_n ^ dsr_prev_ff) | (carrier_det ^ dcd_prev_ff);
    end
  end

  // Previous pin samples feed the change detector
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mchg_ff <= 8'h00;
      dsr_prev_ff <= 8'h00;
      dcd_prev_ff <= 8'h00;
      primed_ff <= 1'b0;
    end else begin
      mchg_ff <= nxt_mchg;
      dsr_prev_ff <= dsr_n;
      dcd_prev_ff <= carrier_det;
      primed_ff <= 1'b1;
    end
  end

  // ==========================================================
  // Interrupt scanner
  // ==========================================================
  // One line per clock, so a waiting cause is seen within eight cycles of unhalted scanning
  assign rx_cause = rx_ready[scan_line_ff] && cmd_ff[scan_line_ff].rcv_int_enable;
  assign tx_cause = tx_ready[scan_line_ff] && cmd_ff[scan_line_ff].xmt_int_enable;

  // Halt on a cause, release on service or when the cause goes away
  always_comb begin
    nxt_scan = scan_ff;
    nxt_scan_line = scan_line_ff;
    nxt_int_line = int_line_ff;
    nxt_dir = dir_ff;
    unique case (scan_ff)
      SC_SCAN: begin
        if (rx_cause) begin
          nxt_scan = SC_HALT;
          nxt_int_line = scan_line_ff;
          nxt_dir = 1'b0;
        end else if (tx_cause) begin
          nxt_scan = SC_HALT;
          nxt_int_line = scan_line_ff;
          nxt_dir = 1'b1;
        end else begin
          nxt_scan_line = scan_line_ff + 3'h1;
        end
      end
      SC_HALT: begin
        // Service access or a vanished cause lets the scan move on
        if ((!dir_ff && (pop[scan_line_ff] || !rx_cause)) ||
            (dir_ff && (load[scan_line_ff] || !tx_cause))) begin
          nxt_scan = SC_SCAN;
          nxt_scan_line = scan_line_ff + 3'h1;
        end
      end
    endcase
    nxt_irq_oe = (nxt_scan == SC_HALT);
  end

  // Line number and direction hold after release
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      scan_ff <= SC_SCAN;
      scan_line_ff <= 3'h0;
      int_line_ff <= 3'h0;
      dir_ff <= 1'b0;
      irq_oe_ff <= 1'b0;
    end else begin
      scan_ff <= nxt_scan;
      scan_line_ff <= nxt_scan_line;
      int_line_ff <= nxt_int_line;
      dir_ff <= nxt_dir;
      irq_oe_ff <= nxt_irq_oe;
    end
  end

  // ==========================================================
  // Bus ready from chip-select edges
  // ==========================================================
  // Edge detect on chip select drives the ready pull-down
  always_comb begin
    nxt_rdy_oe = rdy_oe_ff;
    if (cs_prev_ff && !chip_sel_n) begin
      nxt_rdy_oe = 1'b1;
    end else if (!cs_prev_ff && chip_sel_n) begin
      nxt_rdy_oe = 1'b0;
    end
  end

  // History starts high so leaving reset gives no false edge
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cs_prev_ff <= 1'b1;
      rdy_oe_ff <= 1'b0;
    end else begin
      cs_prev_ff <= chip_sel_n;
      rdy_oe_ff <= nxt_rdy_oe;
    end
  end

  // ==========================================================
  // Read data mux
  // ==========================================================
  // Zero outside read cycles so a stale value is never mistaken
  always_comb begin
    nxt_rdata = RDATA_RST;
    if (rd_stb) begin
      unique case (addr.sel)
        REG_DATA: nxt_rdata = rx_st[addr.line].data;
        REG_STATUS: nxt_rdata = status[addr.line];
        REG_MODE: nxt_rdata = mptr_ff[addr.line] ? mode2_ff[addr.line] : mode1_ff[addr.line];
        REG_CMD: nxt_rdata = cmd_ff[addr.line];
        REG_INT_SUM: nxt_rdata = {4'h0, int_line_ff, dir_ff};
        REG_MDM_SUM: nxt_rdata = mchg_ff;
        default: nxt_rdata = UNMAPPED_RD;
      endcase
    end
  end

  // Read data leave the block from a flop, one cycle late
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= RDATA_RST;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // Open-drain pins only ever pull low
  // Line number pins are meaningful only while the interrupt is driven
  assign rdata = rdata_ff;
  assign rdy_out = 1'b0;
  assign rdy_oe = rdy_oe_ff;
  assign irq_out = 1'b0;
  assign irq_oe = irq_oe_ff;
  assign int_line_num_msb = int_line_ff[2];
  assign int_line_num_mid = int_line_ff[1];
  assign int_line_num_lsb = int_line_ff[0];
  assign service_direction = dir_ff;

endmodule : oasl_top

// ### verif/oasl_props.sv
// Port-level assertions for the octal serial line block
`timescale 1ns/1ns
module oasl_props (
  input wire logic clock, // System clock
  input wire logic arst_n, // Async reset
  input oasl_pkg::oasl_addr_type addr, // Register select
  input wire logic [7:0] wdata, // Write data
  input wire logic wr_stb, // Write strobe
  input wire logic rd_stb, // Read strobe
  input wire logic [7:0] rdata, // Read data
  input wire logic chip_sel_n, // Chip select
  input wire logic rdy_oe, // Ready pulled low
  input wire logic irq_oe, // Interrupt pulled low
  input wire logic int_line_num_msb, // Line bit 2
  input wire logic int_line_num_mid, // Line bit 1
  input wire logic int_line_num_lsb, // Line bit 0
  input wire logic service_direction, // Cause
  input wire logic [7:0] txd, // Serial outputs
  input wire logic [7:0] dsr_n, // Data set ready
  input wire logic [7:0] carrier_det // Carrier pins
);
  import oasl_pkg::*;
  logic [3:0] irq_tag;
  logic [1:0] mdm_sel;
  assign irq_tag = {int_line_num_msb, int_line_num_mid, int_line_num_lsb, service_direction};
  assign mdm_sel = {~dsr_n[addr.line], carrier_det[addr.line]};
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // =====
  // Ready handshake
  sequence cs_fall;
    $fell(chip_sel_n);
  endsequence
  sequence cs_rise;
    $rose(chip_sel_n);
  endsequence
  rdy_take_a: assert property (cs_fall |-> ##[1:2] rdy_oe)
    else $error("ready not driven");
  rdy_drop_a: assert property (cs_rise |-> ##[1:2] !rdy_oe)
    else $error("ready not released");
  rdy_hold_a: assert property (rdy_oe && !chip_sel_n |=> rdy_oe)
    else $error("ready dropped early");
  // =====
  // Serial outputs; idle high can only be seen once reset has gone
  rst_idle_a: assert property ($rose(arst_n) |-> txd == 8'h00 ##1 txd == 8'hFF)
    else $error("txd not low in reset then high");
  brk_low_a: assert property (wr_stb && addr == {3'h0, REG_CMD} && wdata[3]
    |-> ##[1:3] !txd[0])
    else $error("break not driven");
  // =====
  // Interrupt identity and reads
  irq_hold_a: assert property (irq_oe && $past(irq_oe) |-> $stable(irq_tag))
    else $error("line number moved while halted");
  sum_copy_a: assert property (rd_stb && addr.sel == REG_INT_SUM && irq_oe
    |=> rdata == {4'h0, $past(irq_tag)})
    else $error("summary differs from pins");
  rd_quiet_a: assert property (!rd_stb |=> rdata == 8'h00)
    else $error("read data outside read cycle");
  mdm_stat_a: assert property (rd_stb && addr.sel == REG_STATUS
    && $stable(dsr_n) && $stable(carrier_det) |=> rdata[7:6] == $past(mdm_sel))
    else $error("modem status bits wrong");
endmodule : oasl_props

bind oasl_top oasl_props oasl_props_inst (.clock, .arst_n, .addr, .wdata, .wr_stb, .rd_stb,
  .rdata, .chip_sel_n, .rdy_oe, .irq_oe, .int_line_num_msb, .int_line_num_mid,
  .int_line_num_lsb, .service_direction, .txd, .dsr_n, .carrier_det);

// ### verif/oasl_term.sv
// Serial terminal model that sends 8N1 characters into one receive line
`timescale 1ns/1ns
module oasl_term #(
  parameter int BIT = 1041
) (
  input wire logic clock, // System clock
  input wire logic go, // Start one character
  input wire logic [7:0] ch, // Character to send
  output logic line // Serial line to the block
);
  logic [9:0] frame;
  // =====
  // Sender; rests high so every start edge follows a long idle
  initial line = 1'b1;
  always @(posedge clock) begin
    if (go) begin
      frame = {1'b1, ch, 1'b0};
      for (int i = 0; i < 10; i++) begin
        line <= frame[i];
        repeat (BIT) @(posedge clock);
      end
    end
  end
endmodule : oasl_term

// ### verif/oasl_top_tb.sv
// Self-checking bench for the octal serial line block
`timescale 1ns/1ns
module oasl_top_tb;
  import oasl_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  oasl_addr_type addr = '0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic chip_sel_n = 1'b1;
  logic t_go = 1'b0;
  logic [7:0] t_ch = 8'h00;
  logic [7:0] dsr_n = 8'hFF;
  logic [7:0] carrier_det = 8'h00;
  logic [7:0] rdata, txd, got, c0, c1;
  logic rdy_out, rdy_oe, irq_out, irq_oe, ln2, ln1, ln0, dir, t_line;
  logic [9:0] fr;
  int n_fail = 0;
  int n_tests = 0;
  // =====
  // Clock and parts
  always #50 clock = ~clock;
  oasl_top oasl_top_inst (.clock, .arst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
    .chip_sel_n, .rdy_in(~rdy_oe), .rdy_out, .rdy_oe, .irq_in(~irq_oe), .irq_out, .irq_oe,
    .int_line_num_msb(ln2), .int_line_num_mid(ln1), .int_line_num_lsb(ln0),
    .service_direction(dir), .rxd({4'hF, t_line, 3'h7}), .txd, .dsr_n, .carrier_det,
    .factory_test_reset(1'b0));
  oasl_term #(.BIT(BIT_CYC)) oasl_term_inst (.clock, .go(t_go), .ch(t_ch), .line(t_line));
  // =====
  // Helpers
  function automatic logic [7:0] stat(input int i);
    return {~dsr_n[i], carrier_det[i], 6'h00};
  endfunction : stat
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask : wr
  // Read data is taken mid-cycle, the only cycle it stands
  task automatic rd(input logic [5:0] a);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    @(negedge clock);
    got = rdata;
    @(posedge clock); // Hand back on an edge for the next drive
  endtask : rd
  task automatic irq_is(input logic v, input logic [7:0] tag);
    for (int k = 0; k < 40 && irq_oe !== v; k++) @(negedge clock);
    chk({7'h00, irq_oe}, {7'h00, v});
    chk({4'h0, ln2, ln1, ln0, dir}, tag);
  endtask : irq_is
  task automatic send(input logic [7:0] c);
    t_ch <= c;
    t_go <= 1'b1;
    @(posedge clock);
    t_go <= 1'b0;
    repeat (10 * BIT_CYC + 4) @(posedge clock);
  endtask : send
  task automatic close_out();
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  // =====
  // Watchdog, well past three frames
  initial begin
    repeat (50000) @(posedge clock);
    n_fail++;
    close_out();
  end
  // =====
  // Main sequence
  initial begin
    void'($urandom(32'hB1F7D341));
    dsr_n = 8'($urandom());
    carrier_det = 8'($urandom());
    c0 = 8'($urandom());
    c1 = 8'($urandom());
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd({i[2:0], REG_STATUS});
      chk(got, stat(i));
    end
    rd({3'h5, 3'h6});
    chk(got, 8'h00);
    rd({3'h0, REG_CMD});
    chk(got, 8'h00);
    rd({3'h0, REG_MDM_SUM});
    chk(got, 8'h00);
    dsr_n[2] <= ~dsr_n[2];
    carrier_det[5] <= ~carrier_det[5];
    repeat (3) @(posedge clock);
    rd({3'h0, REG_MDM_SUM});
    chk(got, 8'h24);
    rd({3'h2, REG_STATUS});
    chk(got, stat(2));
    chip_sel_n <= 1'b0;
    repeat (3) @(posedge clock);
    chk({7'h00, rdy_oe}, 8'h01);
    chip_sel_n <= 1'b1;
    repeat (3) @(posedge clock);
    chk({7'h00, rdy_oe}, 8'h00);
    chk({6'h00, rdy_out, irq_out}, 8'h00);
    // Held character waits for enable, then leaves LSB first
    wr({3'h0, REG_DATA}, c0);
    repeat (30) @(posedge clock);
    chk({7'h00, txd[0]}, 8'h01);
    wr({3'h0, REG_CMD}, 8'h03);
    for (int k = 0; k < 20 && txd[0] !== 1'b0; k++) @(negedge clock);
    repeat (BIT_CYC / 2) @(posedge clock);
    for (int b = 0; b < 10; b++) begin
      fr[b] = txd[0];
      repeat (BIT_CYC) @(posedge clock);
    end
    chk(fr[8:1], c0);
    chk({6'h00, fr[9], fr[0]}, 8'h02);
    irq_is(1'b1, 8'h01);
    rd({3'h4, REG_INT_SUM});
    chk(got, 8'h01);
    wr({3'h0, REG_DATA}, c1);
    irq_is(1'b0, 8'h01);
    wr({3'h0, REG_CMD}, 8'h08);
    repeat (3) @(posedge clock);
    chk({7'h00, txd[0]}, 8'h00);
    // Two characters fill the receive FIFO of line 3
    wr({3'h3, REG_CMD}, 8'h24);
    send(c0);
    send(c1);
    irq_is(1'b1, 8'h06);
    rd({3'h3, REG_DATA});
    chk(got, c0);
    rd({3'h3, REG_STATUS});
    chk(got, stat(3) | 8'h02);
    irq_is(1'b1, 8'h06);
    rd({3'h3, REG_DATA});
    chk(got, c1);
    rd({3'h3, REG_STATUS});
    chk(got, stat(3));
    irq_is(1'b0, 8'h06);
    close_out();
  end
endmodule : oasl_top_tb
